// file: slpcg_top.sv
/*
  Sleep-mode unit clock gating: the sleep enable register, selection of
  the enable source by power state, bus fault check for unclocked units,
  and an event interrupt, all behind an Avalon-MM slave.
  Assumes the run and deep-sleep enable registers and the automatic
  gating select live elsewhere and arrive here as steady inputs.
*/
`timescale 1ns/1ps

module slpcg_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [slpcg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [slpcg_pkg::DATA_W-1:0] writedata,
  input wire logic [slpcg_pkg::BE_W-1:0] byteenable,
  output logic [slpcg_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // Power state and neighbouring gating registers
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  input wire logic autoGatingSelect,
  input wire logic [slpcg_pkg::DATA_W-1:0] runUnitClockEnables,
  input wire logic [slpcg_pkg::DATA_W-1:0] deepSleepUnitClockEnables,
  // Per-unit clock enables
  output logic [slpcg_pkg::N_UNITS-1:0] unitClockEn,
  // Peripheral access check
  input wire logic periphAccess,
  input wire logic [slpcg_pkg::N_UNITS-1:0] periphSel,
  output logic periphGrant,
  output logic periphFault,
  // Interrupt
  output logic irq
);
  import slpcg_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Expands byte enables to a bit mask
  function automatic logic [DATA_W-1:0] laneMask(
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] m;
    m = RD_ZERO;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Pulls the six unit enables out of a gating register image
  function automatic logic [N_UNITS-1:0] packUnits(
    input logic [DATA_W-1:0] img
  );
    logic [N_UNITS-1:0] u;
    u = UNITS_OFF;
    for (int i = 0; i < N_UNITS; i++) begin
      u[i] = img[UNIT_BIT[i]];
    end
    return u;
  endfunction

  function automatic logic isAddr(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  slpcg_bus_t busSt_q;
  slpcg_bus_t busSt_d;
  logic waitReq_q;
  logic waitReq_d;
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdData_d;
  logic [DATA_W-1:0] sleepEn_q;
  logic [DATA_W-1:0] sleepEn_d;
  slpcg_pwr_t pwr_q;
  slpcg_pwr_t pwr_d;
  logic [N_UNITS-1:0] unitEn_q;
  logic [N_UNITS-1:0] unitEn_d;
  logic grant_q;
  logic grant_d;
  logic fault_q;
  logic fault_d;
  logic [EV_W-1:0] intStat_q;
  logic [EV_W-1:0] intStat_d;
  logic [EV_W-1:0] intMask_q;
  logic [EV_W-1:0] intMask_d;
  logic irq_q;
  logic irq_d;

  logic wrTake;
  logic [DATA_W-1:0] beMask;
  logic [DATA_W-1:0] gateStat;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clrBits;

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  // Write lands at the edge where waitrequest is seen low
  assign wrTake = (busSt_q == BUS_ACK) && write;
  assign beMask = laneMask(byteenable);

  always_comb begin
    gateStat = RD_ZERO;
    gateStat[GS_EN_LSB +: N_UNITS] = unitEn_q;
    gateStat[GS_MODE_LSB +: $bits(slpcg_pwr_t)] = pwr_q;
  end

  always_comb begin
    busSt_d = busSt_q;
    waitReq_d = 1'b1;
    rdData_d = rdData_q;
    case (busSt_q)
      BUS_IDLE: begin
        if (read || write) begin
          busSt_d = BUS_ACK;
          waitReq_d = 1'b0;
          rdData_d = RD_ZERO;
          if (read) begin
            if (isAddr(address, SLEEP_EN_OFS)) begin
              // Reserved bits are never stored, so they read zero
              rdData_d = sleepEn_q & SLEEP_EN_MASK;
            end else if (isAddr(address, INT_STAT_OFS)) begin
              rdData_d[EV_W-1:0] = intStat_q;
            end else if (isAddr(address, INT_MASK_OFS)) begin
              rdData_d[EV_W-1:0] = intMask_q;
            end else if (isAddr(address, GATE_STAT_OFS)) begin
              rdData_d = gateStat;
            end
          end
        end
      end
      BUS_ACK: begin
        busSt_d = BUS_IDLE;
      end
      default: begin
        busSt_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busSt_q <= BUS_IDLE;
      waitReq_q <= 1'b1;
      rdData_q <= RD_ZERO;
    end else begin
      busSt_q <= busSt_d;
      waitReq_q <= waitReq_d;
      rdData_q <= rdData_d;
    end
  end

  // ****************************************************************
  // Sleep enable register
  // ****************************************************************
  always_comb begin
    sleepEn_d = sleepEn_q;
    if (wrTake && isAddr(address, SLEEP_EN_OFS)) begin
      // Only the six enable bits take a write
      sleepEn_d = ((sleepEn_q & ~beMask) | (writedata & beMask))
        & SLEEP_EN_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sleepEn_q <= SLEEP_EN_RESET;
    end else begin
      sleepEn_q <= sleepEn_d;
    end
  end

  // ****************************************************************
  // Power state and enable source
  // ****************************************************************
  always_comb begin
    pwr_d = PWR_RUN;
    if (autoGatingSelect) begin
      if (deepSleepReq) begin
        pwr_d = PWR_DEEP;
      end else if (sleepReq) begin
        pwr_d = PWR_SLEEP;
      end
    end
  end

  always_comb begin
    case (pwr_d)
      PWR_RUN: begin
        unitEn_d = packUnits(runUnitClockEnables);
      end
      PWR_SLEEP: begin
        unitEn_d = packUnits(sleepEn_q);
      end
      PWR_DEEP: begin
        unitEn_d = packUnits(deepSleepUnitClockEnables);
      end
      default: begin
        unitEn_d = UNITS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_q <= PWR_RUN;
      unitEn_q <= UNITS_OFF;
    end else begin
      pwr_q <= pwr_d;
      unitEn_q <= unitEn_d;
    end
  end

  // ****************************************************************
  // Peripheral access check
  // ****************************************************************

  // Any selected unit that is unclocked turns the access into a fault
  always_comb begin
    fault_d = periphAccess && (|(periphSel & ~unitEn_q));
    grant_d = periphAccess && !fault_d;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      grant_q <= grant_d;
    end
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  always_comb begin
    events = EV_RESET;
    events[EV_BUS_FAULT] = fault_d;
    events[EV_MODE_CHANGE] = (pwr_d != pwr_q);
    clrBits = EV_RESET;
    if (wrTake && isAddr(address, INT_STAT_OFS) && byteenable[0]) begin
      clrBits = writedata[EV_W-1:0];
    end
    // A new event beats a clear in the same cycle
    intStat_d = (intStat_q & ~clrBits) | events;
    intMask_d = intMask_q;
    if (wrTake && isAddr(address, INT_MASK_OFS) && byteenable[0]) begin
      intMask_d = writedata[EV_W-1:0];
    end
    irq_d = |(intStat_d & intMask_d);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      intStat_q <= EV_RESET;
      intMask_q <= EV_RESET;
      irq_q <= 1'b0;
    end else begin
      intStat_q <= intStat_d;
      intMask_q <= intMask_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign readdata = rdData_q;
  assign waitrequest = waitReq_q;
  assign unitClockEn = unitEn_q;
  assign periphGrant = grant_q;
  assign periphFault = fault_q;
  assign irq = irq_q;

endmodule

// file: slpcg_pkg.sv
/*
  Constants, register map and state types for the sleep-mode unit clock
  gating block.
  Assumes a single 250 MHz system clock and an Avalon-MM register port.
*/
// Operation
// - Each implemented enable bit clocks one peripheral when set and stops it when clear.
// - An access aimed at a peripheral whose clock is gated off answers with a bus fault.
// - After reset every bit of the sleep enable register is zero, so all units are unclocked in sleep.
// - Unit enables come from the run register when running, this register in sleep, the deep-sleep register in deep sleep.
// - The sleep and deep-sleep registers apply only while the automatic gating select is set.
// - Bit 25 enables comparator B and bit 24 enables comparator A.
// - Bit 17 enables general-purpose counter B and bit 16 enables counter A.
// - Bit 4 enables the synchronous serial port.
// - Bit 0 enables the asynchronous serial port.

package slpcg_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int N_UNITS = 6;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] SLEEP_EN_OFS = 12'h114;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 12'h200;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 12'h204;
  localparam logic [ADDR_W-1:0] GATE_STAT_OFS = 12'h208;

  // ****************************************************************
  // Sleep enable register layout
  // ****************************************************************
  localparam logic [DATA_W-1:0] SLEEP_EN_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SLEEP_EN_MASK = 32'h0303_0011;
  localparam int ASYNC_SERIAL_BIT = 0;
  localparam int SYNC_SERIAL_BIT = 4;
  localparam int GP_COUNTER_A_BIT = 16;
  localparam int GP_COUNTER_B_BIT = 17;
  localparam int COMPARATOR_A_BIT = 24;
  localparam int COMPARATOR_B_BIT = 25;
  // Unit index to register bit position
  localparam int UNIT_BIT [N_UNITS] = '{ASYNC_SERIAL_BIT, SYNC_SERIAL_BIT,
    GP_COUNTER_A_BIT, GP_COUNTER_B_BIT, COMPARATOR_A_BIT, COMPARATOR_B_BIT};

  // ****************************************************************
  // Interrupt and gate status layout
  // ****************************************************************
  localparam int EV_W = 2;
  localparam int EV_BUS_FAULT = 0;
  localparam int EV_MODE_CHANGE = 1;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;
  localparam int GS_EN_LSB = 0;
  localparam int GS_MODE_LSB = 8;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  localparam logic [N_UNITS-1:0] UNITS_OFF = 6'h00;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } slpcg_bus_t;

  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_DEEP = 3'b100
  } slpcg_pwr_t;

endpackage

// file: slpcg_assertions.sv
/*
  Checker for the sleep-mode unit clock gating top, bound to it.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module slpcg_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [slpcg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [slpcg_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  // Power state sources
  input wire logic deepSleepReq,
  input wire logic autoGatingSelect,
  input wire logic [slpcg_pkg::DATA_W-1:0] runUnitClockEnables,
  input wire logic [slpcg_pkg::DATA_W-1:0] deepSleepUnitClockEnables,
  // Units and interrupt
  input wire logic [slpcg_pkg::N_UNITS-1:0] unitClockEn,
  input wire logic periphAccess,
  input wire logic [slpcg_pkg::N_UNITS-1:0] periphSel,
  input wire logic periphGrant,
  input wire logic periphFault,
  input wire logic irq
);
  import slpcg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ********************
  // Properties
  // ********************
  // Register image to unit order of unitClockEn
  function automatic logic [N_UNITS-1:0] fold(input logic [DATA_W-1:0] v);
    return {v[25], v[24], v[17], v[16], v[4], v[0]};
  endfunction
  sequence busReq_s;
    (read || write) && waitrequest;
  endsequence
  sequence busAck_s;
    !waitrequest ##1 waitrequest;
  endsequence

  fault_gated_a: assert property (
    periphAccess && |(periphSel & ~unitClockEn) |=> periphFault)
    else $error("no fault for an unclocked unit");
  grant_clocked_a: assert property (
    periphAccess && !(|(periphSel & ~unitClockEn))
    |=> periphGrant && !periphFault) else $error("clocked unit not granted");
  answer_idle_a: assert property (
    !periphAccess |=> !periphGrant && !periphFault)
    else $error("answer without an access");
  reset_off_a: assert property (
    $fell(rst) |-> unitClockEn == UNITS_OFF && waitrequest && !irq)
    else $error("units not off after reset");
  run_source_a: assert property (
    !autoGatingSelect |=> unitClockEn == fold($past(runUnitClockEnables)))
    else $error("run source not used");
  deep_source_a: assert property (
    autoGatingSelect && deepSleepReq
    |=> unitClockEn == fold($past(deepSleepUnitClockEnables)))
    else $error("deep sleep source not used");
  reserved_zero_a: assert property (
    read && waitrequest && address == SLEEP_EN_OFS
    |=> (readdata & ~SLEEP_EN_MASK) == RD_ZERO) else $error("reserved set");
  bus_wait_a: assert property (busReq_s |=> busAck_s)
    else $error("bus answer not after one wait cycle");
endmodule

bind slpcg_top slpcg_assertions u_slpcg_assertions (.clk, .rst, .address,
  .read, .write, .readdata, .waitrequest, .deepSleepReq, .autoGatingSelect,
  .runUnitClockEnables, .deepSleepUnitClockEnables, .unitClockEn,
  .periphAccess, .periphSel, .periphGrant, .periphFault, .irq);

// file: slpcg_core_model.sv
/*
  Core-side model making one peripheral access at a time.
  Assumes the bench calls access from just after a clock edge.
*/
`timescale 1ns/1ps

module slpcg_core_model (
  // Clock
  input wire logic clk,
  // Peripheral access
  output logic periphAccess,
  output logic [slpcg_pkg::N_UNITS-1:0] periphSel,
  input wire logic periphGrant,
  input wire logic periphFault
);
  import slpcg_pkg::*;
  initial begin
    periphAccess = 1'b0;
    periphSel = UNITS_OFF;
  end

  // ********************
  // Access
  // ********************
  // Idle cycles model a slow core; a released select shows its inverse
  task automatic access(input int idle, input logic [N_UNITS-1:0] sel,
      output logic fault, output logic grant);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    periphAccess <= 1'b1;
    periphSel <= sel;
    @(posedge clk);
    periphAccess <= 1'b0;
    periphSel <= ~sel;
    @(posedge clk);
    fault = periphFault;
    grant = periphGrant;
  endtask
endmodule

// file: testbench.sv
/*
  Self-checking bench for the sleep-mode unit clock gating top.
  Assumes the checker is bound and the core model drives peripheral access.
*/
`timescale 1ns/1ps

module testbench;
  import slpcg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] address = 12'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = 32'h0000_0000;
  logic [BE_W-1:0] byteenable = 4'hf;
  logic sleepReq = 1'b0;
  logic deepSleepReq = 1'b0;
  logic autoGatingSelect = 1'b0;
  logic [DATA_W-1:0] runUnitClockEnables = 32'h0000_0000;
  logic [DATA_W-1:0] deepSleepUnitClockEnables = 32'h0000_0000;
  logic [DATA_W-1:0] readdata, q;
  logic [N_UNITS-1:0] unitClockEn, periphSel;
  logic waitrequest, periphAccess, periphGrant, periphFault, irq, f, g;
  int n_mismatch = 0;
  int total_checks = 0;

  always #2 clk = ~clk;

  slpcg_top u_slpcg_top (.clk, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .sleepReq, .deepSleepReq,
    .autoGatingSelect, .runUnitClockEnables, .deepSleepUnitClockEnables,
    .unitClockEn, .periphAccess, .periphSel, .periphGrant, .periphFault,
    .irq);
  slpcg_core_model u_slpcg_core_model (.clk, .periphAccess, .periphSel,
    .periphGrant, .periphFault);

  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low; data taken at that edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    int i;
    i = 0;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 64);
    if (i >= 64) n_mismatch++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  // ********************
  // Tests
  // ********************
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, SLEEP_EN_OFS, RD_ZERO);
    check(q, SLEEP_EN_RESET);
    check(32'(unitClockEn), 32'h0000_0000);
    bus(1'b0, 12'h0f0, RD_ZERO);
    check(q, RD_ZERO);
    $display("Test reset done");
    bus(1'b1, SLEEP_EN_OFS, 32'hffff_ffff);
    bus(1'b0, SLEEP_EN_OFS, RD_ZERO);
    check(q, SLEEP_EN_MASK);
    bus(1'b1, SLEEP_EN_OFS, q & ~32'h0000_0010);
    bus(1'b0, SLEEP_EN_OFS, RD_ZERO);
    check(q, 32'h0303_0001);
    $display("Test reserved bits done");
    // Run source all on, so only the sleep image can explain a match
    autoGatingSelect <= 1'b1;
    sleepReq <= 1'b1;
    runUnitClockEnables <= 32'h0303_0011;
    for (int u = 0; u < N_UNITS; u++) begin
      bus(1'b1, SLEEP_EN_OFS, 32'h1 << UNIT_BIT[u]);
      repeat (2) @(posedge clk);
      check(32'(unitClockEn), 32'h1 << u);
      u_slpcg_core_model.access(u, 6'h01 << u, f, g);
      check({30'h0, f, g}, 32'h1);
      u_slpcg_core_model.access(0, ~(6'h01 << u), f, g);
      check({30'h0, f, g}, 32'h2);
    end
    $display("Test sleep gating done");
    autoGatingSelect <= 1'b0;
    runUnitClockEnables <= 32'h0001_0010;
    repeat (2) @(posedge clk);
    check(32'(unitClockEn), 32'h0000_0006);
    autoGatingSelect <= 1'b1;
    deepSleepReq <= 1'b1;
    deepSleepUnitClockEnables <= 32'h0200_0001;
    repeat (2) @(posedge clk);
    check(32'(unitClockEn), 32'h0000_0021);
    deepSleepReq <= 1'b0;
    sleepReq <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(unitClockEn), 32'h0000_0006);
    bus(1'b0, GATE_STAT_OFS, RD_ZERO);
    check(q, 32'h0000_0106);
    $display("Test source select done");
    bus(1'b1, INT_MASK_OFS, 32'h0000_0000);
    bus(1'b1, INT_STAT_OFS, 32'h0000_0003);
    u_slpcg_core_model.access(0, 6'h01, f, g);
    check(32'(irq), 32'h0);
    bus(1'b0, INT_STAT_OFS, RD_ZERO);
    check(q & 32'h1, 32'h1);
    bus(1'b1, INT_MASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h1);
    bus(1'b1, INT_STAT_OFS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    $display("Test interrupt done");
    bus(1'b1, INT_MASK_OFS, 32'h0000_0002);
    sleepReq <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h1);
    bus(1'b0, INT_STAT_OFS, RD_ZERO);
    check(q, 32'h0000_0002);
    bus(1'b1, INT_STAT_OFS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    $display("Test mode change interrupt done");
    // Lane 0 only: the upper enables keep their stored values
    byteenable <= 4'h1;
    bus(1'b1, SLEEP_EN_OFS, 32'hffff_ffff);
    byteenable <= 4'hf;
    bus(1'b0, SLEEP_EN_OFS, RD_ZERO);
    check(q, 32'h0200_0011);
    check(32'(unitClockEn), 32'h0000_0023);
    // Reset in mid-run must wipe the enables and the mask again
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, SLEEP_EN_OFS, RD_ZERO);
    check(q, SLEEP_EN_RESET);
    check(32'(unitClockEn), 32'h0000_0000);
    bus(1'b0, INT_MASK_OFS, RD_ZERO);
    check(q, RD_ZERO);
    $display("Test lanes and reset done");
    complete_run();
  end
endmodule
